// *** rtl/mrs_defines.vh ***
// Constants for the motor run sequencer
`ifndef MRS_DEFINES_VH
`define MRS_DEFINES_VH
// Register byte addresses
`define MRS_ADDR_SW_ENABLE 8'h00
`define MRS_ADDR_HW_ENABLE 8'h04
`define MRS_ADDR_CMD 8'h08
`define MRS_ADDR_CONFIG 8'h0C
`define MRS_ADDR_STATUS 8'h10
`define MRS_ADDR_SPEED_REF 8'h14
`define MRS_ADDR_JOG_REF 8'h18
`define MRS_ADDR_SPEED_OUT 8'h1C
// Command register fields
`define MRS_CMD_RUN_FWD 0
`define MRS_CMD_JOG 1
`define MRS_CMD_RUN_REV 2
`define MRS_CMD_DIR 3
`define MRS_CMD_RUN 4
`define MRS_CMD_NOT_STOP 5
// Config register fields
`define MRS_CFG_LATCH_EN 0
`define MRS_CFG_KEYPAD_SEL 1
`define MRS_CFG_DIR_KEY_EN 2
// Status register fields
`define MRS_ST_RUN 0
`define MRS_ST_REVERSE 1
`define MRS_ST_JOG_SEL 2
`define MRS_ST_POWER 3
`define MRS_ST_EN_LOCK 4
`define MRS_ST_HW_EN 5
// Reset values
`define MRS_RST_SW_ENABLE 1'b1
`define MRS_RST_HW_ENABLE 1'b1
`define MRS_RST_CMD 6'h00
`define MRS_RST_CONFIG 3'h0
// Times
`define MRS_CLK_HZ 100000000
`define MRS_DIR_DELAY_MS 65
`define MRS_REEN_DELAY_MS 2000
`define MRS_JOG_HOLD_MS 100
`define MRS_BRESP_OKAY 2'h0
`define MRS_BRESP_SLVERR 2'h2
`endif

// *** rtl/mrs_motor_run_sequencer.v ***
// Motor run sequencer with AXI4-Lite register access
// Summary of operation
// - Software enable at 0 inhibits running; running allowed only while it is 1.
// - Hardware enable forced to 1 when no terminal is an enable terminal.
// - Enable terminal state overrides any written hardware enable value.
// - With enable terminal, fixed 2 s lockout before re-enabling after disable.
// - Six command bits are read/write, volatile, cleared to 0 at power-up.
// - Keypad reference ignores command bits; run/stop keys act, direction key if enabled.
// - Run-forward and run-reverse checked first; exactly one set runs that way.
// - Both clear and run set: direction bit picks, 0 forward, 1 reverse.
// - Jog bit set switches reference selection to jog.
// - Jog speed only when a run command is also active, or during the 100 ms jog hold after it.
// - Run-forward/reverse assertion or swap waits 65 ms before acting.
// - Run plus direction bit commands skip the 65 ms delay.
// - Latching mode latches three run inputs; partner supplies not-stop.
// - All three run latches clear when not-stop goes inactive.
// - Latching disabled makes the run latches transparent.
// - Setting one direction latch clears the opposite one.
// - Jog selection held 100 ms after stopping from jog speed.
// - Run before jog uses normal reference, then jog once jog is active.
// - Power stage active only while drive enable is active.
// - Reverse direction negates the speed reference.
// - Hold timer asserts immediately, releases after timeout once input drops.
`timescale 1ns/1ps
`include "mrs_defines.vh"
module mrs_motor_run_sequencer #(
  parameter REF_W = 16,
  parameter DIR_CYCLES = `MRS_CLK_HZ / 1000 * `MRS_DIR_DELAY_MS,
  parameter REEN_CYCLES = `MRS_CLK_HZ / 1000 * `MRS_REEN_DELAY_MS,
  parameter JOG_CYCLES = `MRS_CLK_HZ / 1000 * `MRS_JOG_HOLD_MS
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire enable_term_cfg,
  input wire enable_term_in,
  input wire key_run,
  input wire key_stop,
  input wire key_dir,
  output wire run_out,
  output wire reverse_out,
  output wire jog_sel_out,
  output wire power_enable,
  output wire [REF_W-1:0] speed_ref_out
);
  localparam CW = 28;
  localparam [31:0] DIR_W = DIR_CYCLES;
  localparam [31:0] REEN_W = REEN_CYCLES;
  localparam [31:0] JOG_W = JOG_CYCLES;
  // Counters are narrower than the integer parameters; cut on purpose
  localparam [CW-1:0] DIR_N = DIR_W[CW-1:0];
  localparam [CW-1:0] REEN_N = REEN_W[CW-1:0];
  localparam [CW-1:0] JOG_N = JOG_W[CW-1:0];

  // Pin inputs pass two flip-flops before use
  reg [4:0] sync1_reg;
  reg [4:0] sync2_reg;
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end else begin
      sync1_reg <= {key_dir, key_stop, key_run, enable_term_in, enable_term_cfg};
      sync2_reg <= sync1_reg;
    end
  end
  wire term_cfg = sync2_reg[0];
  wire term_in = sync2_reg[1];
  wire k_run = sync2_reg[2];
  wire k_stop = sync2_reg[3];
  wire k_dir = sync2_reg[4];

  // Registers
  reg sw_enable_reg;
  reg hw_enable_reg;
  reg [5:0] cmd_reg;
  reg [2:0] config_reg;
  reg [REF_W-1:0] speed_ref_reg;
  reg [REF_W-1:0] jog_ref_reg;

  // AXI write channel: address and data taken in either order
  reg aw_held_reg;
  reg [7:0] aw_addr_reg;
  reg w_held_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  wire aw_have = aw_held_reg || (s_axi_awvalid && s_axi_awready);
  wire w_have = w_held_reg || (s_axi_wvalid && s_axi_wready);
  wire [7:0] wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
  wire [3:0] wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
  wire wr_do = aw_have && w_have && !bvalid_reg;
  wire wr_hit = (wr_addr == `MRS_ADDR_SW_ENABLE) || (wr_addr == `MRS_ADDR_HW_ENABLE) ||
                (wr_addr == `MRS_ADDR_CMD) || (wr_addr == `MRS_ADDR_CONFIG) ||
                (wr_addr == `MRS_ADDR_SPEED_REF) || (wr_addr == `MRS_ADDR_JOG_REF);
  wire wr_b0 = wr_do && wr_strb[0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `MRS_BRESP_OKAY;
    end else begin
      if (wr_do) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? `MRS_BRESP_OKAY : `MRS_BRESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held_reg <= 1'b1;
          aw_addr_reg <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held_reg <= 1'b1;
          w_data_reg <= s_axi_wdata;
          w_strb_reg <= s_axi_wstrb;
        end
        if (bvalid_reg && s_axi_bready) begin
          bvalid_reg <= 1'b0;
        end
      end
    end
  end

  // Register stores; command bits volatile and cleared at reset
  always @(posedge aclk) begin
    if (!aresetn) begin
      sw_enable_reg <= `MRS_RST_SW_ENABLE;
      hw_enable_reg <= `MRS_RST_HW_ENABLE;
      cmd_reg <= `MRS_RST_CMD;
      config_reg <= `MRS_RST_CONFIG;
      speed_ref_reg <= {REF_W{1'b0}};
      jog_ref_reg <= {REF_W{1'b0}};
    end else begin
      if (wr_b0 && wr_addr == `MRS_ADDR_SW_ENABLE) begin
        sw_enable_reg <= wr_data[0];
      end
      if (wr_b0 && wr_addr == `MRS_ADDR_HW_ENABLE) begin
        hw_enable_reg <= wr_data[0];
      end
      if (wr_b0 && wr_addr == `MRS_ADDR_CMD) begin
        cmd_reg <= wr_data[5:0];
      end
      if (wr_b0 && wr_addr == `MRS_ADDR_CONFIG) begin
        config_reg <= wr_data[2:0];
      end
      if (wr_do && wr_addr == `MRS_ADDR_SPEED_REF && wr_strb[1:0] == 2'h3) begin
        speed_ref_reg <= wr_data[REF_W-1:0];
      end
      if (wr_do && wr_addr == `MRS_ADDR_JOG_REF && wr_strb[1:0] == 2'h3) begin
        jog_ref_reg <= wr_data[REF_W-1:0];
      end
    end
  end

  // Effective hardware enable: terminal overrides, else forced to 1
  wire hw_en_eff = term_cfg ? term_in : 1'b1;
  wire hw_en_written = hw_enable_reg; // Stored value, read back only

  // Re-enable lockout counts after the terminal disables the drive
  reg [CW-1:0] reen_cnt_reg;
  always @(posedge aclk) begin
    if (!aresetn) begin
      reen_cnt_reg <= {CW{1'b0}};
    end else if (term_cfg && !term_in) begin
      reen_cnt_reg <= REEN_N;
    end else if (reen_cnt_reg != {CW{1'b0}}) begin
      reen_cnt_reg <= reen_cnt_reg - 1'b1;
    end
  end
  wire lockout = reen_cnt_reg != {CW{1'b0}};
  wire drive_enable = sw_enable_reg && hw_en_eff && !lockout;

  // Command bits; keypad mode disregards them all
  wire keypad = config_reg[`MRS_CFG_KEYPAD_SEL];
  wire latch_en = config_reg[`MRS_CFG_LATCH_EN];
  wire c_fwd = cmd_reg[`MRS_CMD_RUN_FWD] && !keypad;
  wire c_rev = cmd_reg[`MRS_CMD_RUN_REV] && !keypad;
  wire c_run = cmd_reg[`MRS_CMD_RUN] && !keypad;
  wire c_jog = cmd_reg[`MRS_CMD_JOG] && !keypad;
  wire c_dir = cmd_reg[`MRS_CMD_DIR];
  wire c_nstop = cmd_reg[`MRS_CMD_NOT_STOP];

  // Run latches for momentary inputs
  reg lat_fwd_reg;
  reg lat_rev_reg;
  reg lat_run_reg;
  always @(posedge aclk) begin
    if (!aresetn || !c_nstop || keypad) begin
      lat_fwd_reg <= 1'b0;
      lat_rev_reg <= 1'b0;
      lat_run_reg <= 1'b0;
    end else begin
      // A single direction set clears the opposite latch
      if (c_fwd && !c_rev) begin
        lat_fwd_reg <= 1'b1;
        lat_rev_reg <= 1'b0;
      end else if (c_rev && !c_fwd) begin
        lat_rev_reg <= 1'b1;
        lat_fwd_reg <= 1'b0;
      end
      if (c_run) begin
        lat_run_reg <= 1'b1;
      end
    end
  end
  wire r_fwd = latch_en ? lat_fwd_reg : c_fwd;
  wire r_rev = latch_en ? lat_rev_reg : c_rev;
  wire r_run = latch_en ? lat_run_reg : c_run;

  // Direction-run pair: exactly one set gives a command, both set gives none
  wire dr_fwd = r_fwd && !r_rev;
  wire dr_rev = r_rev && !r_fwd;

  // 65 ms delay on assertion or swap of the direction-run pair
  reg [1:0] dr_last_reg;
  reg [CW-1:0] dir_cnt_reg;
  always @(posedge aclk) begin
    if (!aresetn) begin
      dr_last_reg <= 2'h0;
      dir_cnt_reg <= {CW{1'b0}};
    end else begin
      dr_last_reg <= {dr_rev, dr_fwd};
      if ({dr_rev, dr_fwd} != dr_last_reg && (dr_fwd || dr_rev)) begin
        dir_cnt_reg <= DIR_N;
      end else if (dir_cnt_reg != {CW{1'b0}}) begin
        dir_cnt_reg <= dir_cnt_reg - 1'b1;
      end
    end
  end
  wire dr_ready = dir_cnt_reg == {CW{1'b0}} && {dr_rev, dr_fwd} == dr_last_reg;

  // Keypad run/stop and direction toggling
  reg key_run_reg;
  reg key_rev_reg;
  reg kdir_last_reg;
  always @(posedge aclk) begin
    if (!aresetn) begin
      key_run_reg <= 1'b0;
      key_rev_reg <= 1'b0;
      kdir_last_reg <= 1'b0;
    end else begin
      kdir_last_reg <= k_dir;
      if (!keypad || k_stop) begin
        key_run_reg <= 1'b0;
      end else if (k_run) begin
        key_run_reg <= 1'b1;
      end
      if (keypad && config_reg[`MRS_CFG_DIR_KEY_EN] && k_dir && !kdir_last_reg) begin
        key_rev_reg <= !key_rev_reg;
      end
    end
  end

  // Run request and direction; run plus direction bit is immediate
  reg run_reg;
  reg rev_reg;
  reg run_req;
  reg rev_req;
  always @* begin
    run_req = 1'b0;
    rev_req = 1'b0;
    if (keypad) begin
      run_req = key_run_reg;
      rev_req = key_rev_reg;
    end else if (dr_fwd || dr_rev) begin
      // Hold present state during the delay, so a swap never passes through stop
      run_req = dr_ready ? 1'b1 : run_reg;
      rev_req = dr_ready ? dr_rev : rev_reg;
    end else if (!r_fwd && !r_rev && r_run) begin
      run_req = 1'b1;
      rev_req = c_dir;
    end
  end

  // Jog selection hold timer: immediate on, 100 ms release
  wire jog_active = c_jog && run_req && drive_enable;
  reg [CW-1:0] jog_cnt_reg;
  always @(posedge aclk) begin
    if (!aresetn) begin
      jog_cnt_reg <= {CW{1'b0}};
    end else if (jog_active) begin
      jog_cnt_reg <= JOG_N;
    end else if (jog_cnt_reg != {CW{1'b0}}) begin
      jog_cnt_reg <= jog_cnt_reg - 1'b1;
    end
  end
  wire jog_hold = jog_active || (jog_cnt_reg != {CW{1'b0}});
  // Jog bit alone selects the jog reference; running needs a run command too
  wire jog_sel = c_jog || jog_hold;

  // Registered outputs
  reg jog_sel_reg;
  reg power_reg;
  reg [REF_W-1:0] speed_out_reg;
  wire [REF_W-1:0] ref_mag = jog_sel ? jog_ref_reg : speed_ref_reg;
  always @(posedge aclk) begin
    if (!aresetn) begin
      run_reg <= 1'b0;
      rev_reg <= 1'b0;
      jog_sel_reg <= 1'b0;
      power_reg <= 1'b0;
      speed_out_reg <= {REF_W{1'b0}};
    end else begin
      run_reg <= run_req && drive_enable;
      rev_reg <= rev_req;
      jog_sel_reg <= jog_sel;
      power_reg <= drive_enable && (run_req || jog_hold);
      if (!(run_req && drive_enable) && !jog_hold) begin
        speed_out_reg <= {REF_W{1'b0}};
      end else if (rev_req) begin
        speed_out_reg <= {REF_W{1'b0}} - ref_mag;
      end else begin
        speed_out_reg <= ref_mag;
      end
    end
  end
  assign run_out = run_reg;
  assign reverse_out = rev_reg;
  assign jog_sel_out = jog_sel_reg;
  assign power_enable = power_reg;
  assign speed_ref_out = speed_out_reg;

  // AXI read channel
  reg rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;
  reg [31:0] rd_mux;
  reg rd_hit;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  always @* begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `MRS_ADDR_SW_ENABLE: rd_mux[0] = sw_enable_reg;
      `MRS_ADDR_HW_ENABLE: rd_mux[0] = term_cfg ? term_in : hw_en_written;
      `MRS_ADDR_CMD: rd_mux[5:0] = cmd_reg;
      `MRS_ADDR_CONFIG: rd_mux[2:0] = config_reg;
      `MRS_ADDR_STATUS: rd_mux[5:0] = {hw_en_eff, lockout, power_reg, jog_sel_reg, rev_reg, run_reg};
      `MRS_ADDR_SPEED_REF: rd_mux[REF_W-1:0] = speed_ref_reg;
      `MRS_ADDR_JOG_REF: rd_mux[REF_W-1:0] = jog_ref_reg;
      `MRS_ADDR_SPEED_OUT: rd_mux[REF_W-1:0] = speed_out_reg;
      default: rd_hit = 1'b0;
    endcase
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `MRS_BRESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= rd_hit ? `MRS_BRESP_OKAY : `MRS_BRESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
endmodule

// *** test/mrs_panel_model.sv ***
// Terminal and keypad model driving the sequencer's pin inputs
`timescale 1ns/1ps
module mrs_panel_model (
  input wire aclk,
  input wire [4:0] req,
  output logic enable_term_cfg,
  output logic enable_term_in,
  output logic key_run,
  output logic key_stop,
  output logic key_dir
);
  // Idle panel at power-up: no enable terminal, no key pressed
  initial begin
    {key_dir, key_stop, key_run, enable_term_in, enable_term_cfg} = 5'h00;
  end
  // Pins move just after an edge, like a real input scan
  always @(posedge aclk) begin
    {key_dir, key_stop, key_run, enable_term_in, enable_term_cfg} <= req;
  end
endmodule

// *** test/mrs_checker_properties.sv ***
// Port-level assertions for the motor run sequencer
`timescale 1ns/1ps
module mrs_checker (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire run_out,
  input wire power_enable,
  input wire jog_sel_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write channels taken at one edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_taken |=> s_axi_bvalid)
    else $error("write not answered");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read not answered");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_ready: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read ready wrong");
  a_run_power: assert property (run_out |-> power_enable)
    else $error("running without power stage");
  // Jog selection must stay on for 8 cycles after the stop
  a_jog_hold: assert property ($fell(run_out) && jog_sel_out |=> jog_sel_out [*8])
    else $error("jog selection dropped early");
endmodule
bind mrs_motor_run_sequencer mrs_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .run_out(run_out), .power_enable(power_enable), .jog_sel_out(jog_sel_out));

// *** test/tb_top.sv ***
// Self-checking bench for the motor run sequencer
`timescale 1ns/1ps
`include "mrs_defines.vh"
module tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic enable_term_cfg, enable_term_in, key_run, key_stop, key_dir;
  logic run_out, reverse_out, jog_sel_out, power_enable;
  logic [15:0] speed_ref_out, sref;
  logic [4:0] req;
  logic [3:0] s_axi_wstrb;
  logic [2:0] s_axi_prot;
  int n_mismatch, checks, cyc, n, seed, i;
  mrs_motor_run_sequencer #(.DIR_CYCLES(20), .REEN_CYCLES(50), .JOG_CYCLES(30)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_prot),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_prot), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .enable_term_cfg(enable_term_cfg),
    .enable_term_in(enable_term_in), .key_run(key_run), .key_stop(key_stop), .key_dir(key_dir),
    .run_out(run_out), .reverse_out(reverse_out), .jog_sel_out(jog_sel_out),
    .power_enable(power_enable), .speed_ref_out(speed_ref_out));
  mrs_panel_model u_panel (.aclk(aclk), .req(req), .enable_term_cfg(enable_term_cfg),
    .enable_term_in(enable_term_in), .key_run(key_run), .key_stop(key_stop), .key_dir(key_dir));
  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Expected reference: two's complement when reversing
  function automatic logic [15:0] exp_ref(input logic [15:0] r, input logic rev);
    return rev ? 16'h0000 - r : r;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Write: both channels offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // Bounded wait for the run output, cycles counted in n
  task automatic until_run;
    n = 0;
    while (run_out !== 1'b1 && n < 80) begin
      @(posedge aclk);
      n++;
    end
  endtask
  task automatic cmd(input logic [31:0] d);
    wr(`MRS_ADDR_CMD, d, `MRS_BRESP_OKAY);
  endtask
  // Hang guard, well above the whole sequence
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    seed = 95684;
    {n_mismatch, checks, cyc} = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, req} = 53'h0;
    s_axi_wstrb = 4'hF;
    s_axi_prot = 3'($random(seed));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`MRS_ADDR_SW_ENABLE, 32'h1, `MRS_BRESP_OKAY);
    rd(`MRS_ADDR_HW_ENABLE, 32'h1, `MRS_BRESP_OKAY);
    rd(`MRS_ADDR_CMD, 32'h0, `MRS_BRESP_OKAY);
    rd(8'h20, 32'h0, `MRS_BRESP_SLVERR);
    wr(8'h20, 32'h1, `MRS_BRESP_SLVERR);
    // Lane 0 off: the one-bit store must keep its value
    s_axi_wstrb <= 4'hE;
    wr(`MRS_ADDR_SW_ENABLE, 32'h0, `MRS_BRESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(`MRS_ADDR_SW_ENABLE, 32'h1, `MRS_BRESP_OKAY);
    // Random references in both directions via run plus direction
    for (i = 0; i < 4; i++) begin
      sref = $random(seed) & 16'h7FFF | 16'h0001;
      wr(`MRS_ADDR_SPEED_REF, {16'h0, sref}, `MRS_BRESP_OKAY);
      cmd({27'h0, 1'b1, i[0], 3'h0});
      until_run();
      chk1(n <= 3, 1'b1);
      chk1(reverse_out, i[0]);
      chk({16'h0, speed_ref_out}, {16'h0, exp_ref(sref, i[0])});
      cmd(32'h0);
      repeat (4) @(posedge aclk);
    end
    wr(`MRS_ADDR_SW_ENABLE, 32'h0, `MRS_BRESP_OKAY);
    cmd(32'h10);
    repeat (5) @(posedge aclk);
    chk1(run_out, 1'b0);
    chk1(power_enable, 1'b0);
    wr(`MRS_ADDR_SW_ENABLE, 32'h1, `MRS_BRESP_OKAY);
    until_run();
    chk1(n <= 3, 1'b1);
    cmd(32'h0);
    cmd(32'h1);
    until_run();
    chk1(n >= 17 && n <= 24, 1'b1);
    chk1(reverse_out, 1'b0);
    cmd(32'h4);
    repeat (8) @(posedge aclk);
    chk1(reverse_out, 1'b0);
    repeat (20) @(posedge aclk);
    chk1(reverse_out, 1'b1);
    cmd(32'h15);
    repeat (30) @(posedge aclk);
    chk1(run_out, 1'b0);
    // Jog select, jog run, then the hold after stopping
    wr(`MRS_ADDR_JOG_REF, 32'h0123, `MRS_BRESP_OKAY);
    cmd(32'h2);
    repeat (3) @(posedge aclk);
    chk1(jog_sel_out, 1'b1);
    chk1(run_out, 1'b0);
    cmd(32'h12);
    until_run();
    chk({16'h0, speed_ref_out}, 32'h0123);
    cmd(32'h0);
    repeat (12) @(posedge aclk);
    chk1(jog_sel_out, 1'b1);
    repeat (40) @(posedge aclk);
    chk1(jog_sel_out, 1'b0);
    cmd(32'h10);
    until_run();
    chk1(jog_sel_out, 1'b0);
    cmd(32'h12);
    repeat (3) @(posedge aclk);
    chk1(jog_sel_out, 1'b1);
    cmd(32'h0);
    repeat (50) @(posedge aclk);
    // Latching mode: momentary pulses held until not-stop drops
    wr(`MRS_ADDR_CONFIG, 32'h1, `MRS_BRESP_OKAY);
    cmd(32'h30);
    cmd(32'h20);
    repeat (3) @(posedge aclk);
    chk1(run_out, 1'b1);
    cmd(32'h0);
    repeat (3) @(posedge aclk);
    chk1(run_out, 1'b0);
    cmd(32'h21);
    cmd(32'h20);
    repeat (30) @(posedge aclk);
    cmd(32'h24);
    cmd(32'h20);
    repeat (30) @(posedge aclk);
    chk1(reverse_out, 1'b1);
    chk1(run_out, 1'b1);
    cmd(32'h0);
    wr(`MRS_ADDR_CONFIG, 32'h0, `MRS_BRESP_OKAY);
    cmd(32'h30);
    cmd(32'h20);
    repeat (3) @(posedge aclk);
    chk1(run_out, 1'b0);
    // Keypad mode ignores command bits, keys act
    wr(`MRS_ADDR_CONFIG, 32'h2, `MRS_BRESP_OKAY);
    cmd(32'h10);
    repeat (4) @(posedge aclk);
    chk1(run_out, 1'b0);
    req <= 5'h04;
    repeat (6) @(posedge aclk);
    chk1(run_out, 1'b1);
    req <= 5'h08;
    repeat (6) @(posedge aclk);
    chk1(run_out, 1'b0);
    // Direction key acts once enabled
    wr(`MRS_ADDR_CONFIG, 32'h6, `MRS_BRESP_OKAY);
    req <= 5'h10;
    repeat (6) @(posedge aclk);
    chk1(reverse_out, 1'b1);
    req <= 5'h00;
    wr(`MRS_ADDR_CONFIG, 32'h0, `MRS_BRESP_OKAY);
    // Enable terminal overrides the bit and enforces the lockout
    wr(`MRS_ADDR_HW_ENABLE, 32'h0, `MRS_BRESP_OKAY);
    repeat (3) @(posedge aclk);
    chk1(run_out, 1'b1);
    req <= 5'h01;
    repeat (6) @(posedge aclk);
    chk1(power_enable, 1'b0);
    req <= 5'h03;
    repeat (20) @(posedge aclk);
    chk1(power_enable, 1'b0);
    repeat (45) @(posedge aclk);
    chk1(power_enable, 1'b1);
    rd(`MRS_ADDR_HW_ENABLE, 32'h1, `MRS_BRESP_OKAY);
    give_verdict();
  end
endmodule
